// >>> core/tvg_top.sv
// Purpose: text video timing, address and host window
// Assumes: clk is the dot clock; host holds its request
// Notes:   glyph ROM sits outside on glyph_rom_addr/data
`timescale 1ns/100ps
`include "tvg_map.svh"
module tvg_top
  import tvg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        frame_rate_50,
  input  wire logic [10:0] host_addr,
  input  wire logic [7:0]  host_wdata,
  input  wire logic        host_mem_rd,
  input  wire logic        host_mem_wr,
  input  wire logic        host_base_wr,
  input  wire logic [7:0]  glyph_rom_data,
  output logic             pclk,
  output logic             char_tick,
  output logic             line_blank_term,
  output logic             frame_blank_term,
  output logic             host_window_select,
  output logic             hsync,
  output logic             vsync,
  output logic             video_out,
  output logic             host_ready,
  output logic [7:0]       host_rdata,
  output logic [10:0]      vram_addr,
  output logic [10:0]      glyph_rom_addr
);
  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  logic [2:0]  dot_cnt;
  logic [7:0]  hcount;
  logic [7:0]  row;
  logic [7:0]  scroll_base_row;
  logic [7:0]  row_start_bits;
  logic [7:0]  char_addr;
  logic [7:0]  vram_q;
  logic        rev_d;
  logic [7:0]  mem [0:2047];
  logic [3:0]  glyph_line_sel;
  logic        first_line;
  logic        row_tick;
  tvg_host_e   hstate;
  tvg_host_e   next_hstate;

  // ----------------------------------------------------------
  // Decodes
  // ----------------------------------------------------------
  wire [7:0] next_hcount  = (hcount == `TVG_H_LAST) ? `TVG_H_LOAD
                                                    : hcount + 8'h01;
  wire       hblank_start = char_tick && (hcount == `TVG_H_LAST);
  wire       line_start   = char_tick && (next_hcount == 8'h00);
  wire [7:0] v_load       = frame_rate_50 ? `TVG_V50_LOAD
                                          : `TVG_V60_LOAD;
  wire [7:0] next_row     = (row == `TVG_V_LAST) ? v_load
                                                 : row + 8'h01;
  wire       blank        = line_blank_term | frame_blank_term;

  // Upper address counter step and end-of-buffer wrap
  wire [7:0]  char_inc   = char_addr + 8'h01;
  wire        at_end     = ({char_inc, 3'b000} == `TVG_END_ADDR);
  wire [7:0]  next_caddr = at_end ? 8'h00 : char_inc; // RULE14
  wire        col_bit_lo0 = hcount[0];
  wire        col_bit_lo1 = hcount[1];
  wire        col_bit_lo2 = hcount[2];
  wire        char_step  = char_tick && !line_blank_term &&
                           ({col_bit_lo2, col_bit_lo1, col_bit_lo0}
                            == 3'b111);
  wire tvg_addr_t disp_addr = {char_addr, col_bit_lo2, col_bit_lo1,
                               col_bit_lo0}; // RULE12

  // Address multiplexer: host only in horizontal blanking
  wire tvg_addr_t mux_addr = host_window_select ? host_addr
                                                : disp_addr; // RULE16

  // Vertical sync decode per variant
  wire v60_on  = !frame_rate_50 && row == `TVG_V60_SYNC_ON &&
                 glyph_line_sel == `TVG_V60_LINE; // RULE7
  wire v60_off = !frame_rate_50 && row == `TVG_V60_SYNC_OFF &&
                 glyph_line_sel == `TVG_V60_LINE; // RULE7
  wire v50_on  = frame_rate_50 && row == `TVG_V50_SYNC_ON; // RULE8
  wire v50_off = frame_rate_50 && row == `TVG_V50_SYNC_OFF; // RULE8

  // Host access window and request
  wire host_req   = host_mem_rd | host_mem_wr;
  wire host_grant = (hstate == HS_WAIT) && hsync &&
                    host_window_select; // RULE18

  // ----------------------------------------------------------
  // Dot counter and processor clock
  // ----------------------------------------------------------
  // Seven dots per cell; tick while the count reads zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dot_cnt   <= 3'h0; // RULE23
      char_tick <= 1'b0;
      pclk      <= 1'b0;
    end else begin
      dot_cnt   <= (dot_cnt == `TVG_DOT_LAST) ? 3'h0
                                              : dot_cnt + 3'h1; // RULE1
      char_tick <= (dot_cnt == `TVG_DOT_LAST); // RULE1
      pclk      <= ~pclk; // RULE5
    end
  end

  // ----------------------------------------------------------
  // Horizontal timing
  // ----------------------------------------------------------
  // Counter, blanking and sync move together on char_tick
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hcount             <= `TVG_H_LOAD; // RULE23
      line_blank_term    <= 1'b1;
      host_window_select <= 1'b1;
      hsync              <= 1'b0;
    end else if (char_tick) begin
      hcount <= next_hcount; // RULE2 RULE4
      if (next_hcount == `TVG_H_LOAD) begin
        line_blank_term    <= 1'b1; // RULE4
        host_window_select <= 1'b1;
      end else if (next_hcount == 8'h00) begin
        line_blank_term    <= 1'b0; // RULE4
        host_window_select <= 1'b0;
      end
      if (next_hcount == `TVG_H_SYNC_ON)
        hsync <= 1'b1; // RULE3
      else if (next_hcount == `TVG_H_SYNC_OFF)
        hsync <= 1'b0; // RULE3
    end
  end

  // ----------------------------------------------------------
  // Vertical timing
  // ----------------------------------------------------------
  tvg_line_ctr u_line (
    .clk        (clk),
    .rst        (rst),
    .step       (hblank_start),
    .line       (glyph_line_sel),
    .first_line (first_line),
    .row_tick   (row_tick)
  );

  // Row counter and vertical blanking on each row tick
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      row              <= `TVG_V50_LOAD; // RULE23
      frame_blank_term <= 1'b1;
    end else if (row_tick) begin
      row <= next_row; // RULE7 RULE8 RULE9
      if (next_row == v_load)
        frame_blank_term <= 1'b1; // RULE9
      else if (next_row == 8'h00)
        frame_blank_term <= 1'b0; // RULE9
    end
  end

  // Vertical sync flip-flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      vsync <= 1'b0;
    else if (v60_on || v50_on)
      vsync <= 1'b1; // RULE7 RULE8
    else if (v60_off || v50_off)
      vsync <= 1'b0; // RULE7 RULE8
  end

  // ----------------------------------------------------------
  // Linear address generator
  // ----------------------------------------------------------
  // Scroll base register, written by the host at any time
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      scroll_base_row <= `TVG_BASE_RESET;
    else if (host_base_wr)
      scroll_base_row <= host_wdata; // RULE10
  end

  // Row start register: base in vblank, else advanced start
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      row_start_bits <= `TVG_BASE_RESET;
    else if (frame_blank_term)
      row_start_bits <= scroll_base_row; // RULE10 RULE15
    else if (hblank_start && glyph_line_sel == `TVG_LINE_LAST)
      row_start_bits <= next_caddr; // RULE13
  end

  // Character address: reload per line, step per eight
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      char_addr <= `TVG_BASE_RESET;
    else if (line_start && !(first_line && row_tick))
      char_addr <= row_start_bits; // RULE11
    else if (hblank_start && glyph_line_sel != `TVG_LINE_LAST)
      char_addr <= row_start_bits; // RULE11
    else if (char_step)
      char_addr <= next_caddr; // RULE12 RULE14
  end

  // ----------------------------------------------------------
  // Display memory and glyph fetch
  // ----------------------------------------------------------
  // Memory port: display read outside the window, host address inside it
  always_ff @(posedge clk) begin
    vram_q <= mem[mux_addr]; // RULE19
    if (host_grant && host_mem_wr)
      mem[mux_addr] <= host_wdata; // RULE17
  end

  // Glyph address and reverse bit, one stage behind memory
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vram_addr      <= 11'h000;
      glyph_rom_addr <= 11'h000;
      rev_d          <= 1'b0;
    end else begin
      vram_addr      <= mux_addr;
      glyph_rom_addr <= {vram_q[6:0], glyph_line_sel}; // RULE19
      rev_d          <= vram_q[7]; // RULE21
    end
  end

  tvg_dot_shift u_shift (
    .clk               (clk),
    .rst               (rst),
    .char_tick         (char_tick),
    .blank             (blank),
    .glyph_bits        (glyph_rom_data),
    .reverse_video_bit (rev_d),
    .video_out         (video_out)
  );

  // ----------------------------------------------------------
  // Host wait sequencer
  // ----------------------------------------------------------
  // Request waits until sync inside blanking, then one access
  always_comb begin
    next_hstate = hstate;
    case (hstate)
      HS_IDLE: if (host_req) next_hstate = HS_WAIT;
      HS_WAIT: if (host_grant) next_hstate = HS_DONE; // RULE18
      HS_DONE: if (!host_req) next_hstate = HS_IDLE;
      default: next_hstate = HS_IDLE;
    endcase
  end

  // Ready pulse and read data on the granted cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hstate     <= HS_IDLE;
      host_ready <= 1'b0;
      host_rdata <= 8'h00;
    end else begin
      hstate     <= next_hstate;
      host_ready <= host_grant; // RULE18
      if (host_grant && host_mem_rd)
        host_rdata <= mem[mux_addr]; // RULE17
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  sequence s_six_idle;
    !char_tick [*6];
  endsequence

  a_dot_divide: assert property (@(posedge clk) disable iff (rst) // RULE1
    char_tick |=> s_six_idle ##1 char_tick)
    else $error("character tick is not one in seven");
  a_h_load: assert property (@(posedge clk) disable iff (rst) // RULE2
    hblank_start |=> hcount == `TVG_H_LOAD && line_blank_term)
    else $error("horizontal counter not loaded at blanking");
  a_hsync_window: assert property (@(posedge clk) disable iff (rst) // RULE3
    hsync == (hcount >= `TVG_H_SYNC_ON && hcount < `TVG_H_SYNC_OFF))
    else $error("hsync outside its counter window");
  a_hblank_map: assert property (@(posedge clk) disable iff (rst) // RULE4
    line_blank_term == (hcount > `TVG_H_LAST))
    else $error("horizontal blanking does not match counter");
  a_pclk_half: assert property (@(posedge clk) disable iff (rst) // RULE5
    !$past(rst) |-> pclk != $past(pclk))
    else $error("processor clock is not half the dot clock");
  a_vsync_60: assert property (@(posedge clk) disable iff (rst) // RULE7
    v60_on |=> vsync)
    else $error("60 Hz vsync not set at its line");
  a_vsync_50: assert property (@(posedge clk) disable iff (rst) // RULE8
    v50_off |=> !vsync)
    else $error("50 Hz vsync not cleared at its row");
  a_row_reload: assert property (@(posedge clk) disable iff (rst) // RULE9
    row_tick && row == `TVG_V_LAST |=> row == v_load && frame_blank_term)
    else $error("row counter not reloaded after last row");
  a_end_wrap: assert property (@(posedge clk) disable iff (rst) // RULE14
    char_step && at_end && !line_start &&
    !(hblank_start && glyph_line_sel != `TVG_LINE_LAST)
    |=> char_addr == 8'h00)
    else $error("character address not reset at end of buffer");
  a_host_ready: assert property (@(posedge clk) disable iff (rst) // RULE18
    host_ready |-> $past(hsync) && $past(host_window_select))
    else $error("host released outside sync time");
  a_host_blank: assert property (@(posedge clk) disable iff (rst) // RULE17
    host_grant |-> line_blank_term)
    else $error("host reached memory outside blanking");

  // Ready stands one cycle after each grant
  sequence s_ready_pulse;
    host_ready ##1 !host_ready;
  endsequence

  a_ready_pulse: assert property (@(posedge clk) disable iff (rst) // RULE18
    host_grant |=> s_ready_pulse)
    else $error("host ready is not a one-cycle pulse");
  // Vertical sync edges in both variants
  a_vsync_50_set: assert property (@(posedge clk) disable iff (rst) // RULE8
    v50_on |=> vsync)
    else $error("50 Hz vsync not set at its row");
  a_vsync_60_clr: assert property (@(posedge clk) disable iff (rst) // RULE7
    v60_off |=> !vsync)
    else $error("60 Hz vsync not cleared at its line");

  // ----------------------------------------------------------
  // Address generator checks
  // ----------------------------------------------------------
  // Line start reload, per-eight step, row advance, frame base
  a_line_reload: assert property (@(posedge clk) disable iff (rst) // RULE11
    line_start && !(first_line && row_tick)
    |=> char_addr == $past(row_start_bits))
    else $error("character address not reloaded at line start");
  a_char_step: assert property (@(posedge clk) disable iff (rst) // RULE12
    char_step && !at_end &&
    !(hblank_start && glyph_line_sel != `TVG_LINE_LAST)
    |=> char_addr == $past(char_inc))
    else $error("character address did not step per eight");
  a_row_advance: assert property (@(posedge clk) disable iff (rst) // RULE13
    hblank_start && glyph_line_sel == `TVG_LINE_LAST && !frame_blank_term
    |=> row_start_bits == char_addr)
    else $error("row start not advanced after the ninth line");
  a_vblank_base: assert property (@(posedge clk) disable iff (rst) // RULE15
    frame_blank_term |=> row_start_bits == $past(scroll_base_row))
    else $error("row start not taken from base in vertical blanking");
endmodule // tvg_top

// >>> core/tvg_map.svh
// Purpose: constants of the text video timing generator
// Assumes: clk is the dot clock, one dot per clock
// Notes:   offsets, loads and decodes are counter states
//
// Contract
// RULE1 - Dot clock divided by seven gives char_tick
// RULE2 - Horizontal counter loads 226 at blanking
// RULE3 - Hsync on at 236, off at 244
// RULE4 - Shows states 0-71, wraps 255 to 0
// RULE5 - Processor clock is dot clock halved
// RULE6 - Nine glyph lines, first flagged, row tick
// RULE7 - 60 Hz: load 251, vsync 252/253 line 4
// RULE8 - 50 Hz: load 245, vsync 250 to 251
// RULE9 - Rows 0-23 shown, reload after 23
// RULE10 - Host writes scroll base; base for addressing
// RULE11 - Row start reloads char address each line
// RULE12 - Low address bits from counter, upper per eight
// RULE13 - After ninth line store advanced row start
// RULE14 - Address 1728 resets character address counter
// RULE15 - Vertical blanking reloads row start from base
// RULE16 - Host address to memory only in blanking
// RULE17 - Host data reaches memory only in blanking
// RULE18 - Host waits for ready until sync time
// RULE19 - Memory 2048x8; glyph code plus line
// RULE20 - Shifter loads per tick, shifts every dot
// RULE21 - Dot xor reverse bit, then registered
// RULE22 - Combined blanking clears the dot shifter
// RULE23 - Reset puts counters at blanking start; row resets to 245 (the 50 Hz load) in both variants
`ifndef TVG_MAP_SVH
`define TVG_MAP_SVH

// ----------------------------------------------------------
// Timing counts
// ----------------------------------------------------------
`define TVG_DOT_LAST     3'h6
`define TVG_H_LOAD       8'hE2
`define TVG_H_SYNC_ON    8'hEC
`define TVG_H_SYNC_OFF   8'hF4
`define TVG_H_LAST       8'h47
`define TVG_LINE_LAST    4'h8
`define TVG_V_LAST       8'h17
`define TVG_V60_LOAD     8'hFB
`define TVG_V60_SYNC_ON  8'hFC
`define TVG_V60_SYNC_OFF 8'hFD
`define TVG_V60_LINE     4'h4
`define TVG_V50_LOAD     8'hF5
`define TVG_V50_SYNC_ON  8'hFA
`define TVG_V50_SYNC_OFF 8'hFB
`define TVG_END_ADDR     11'h6C0
`define TVG_BASE_RESET   8'h00
`define TVG_DOT_NS       89
`define TVG_CLK_NS       50
`define TVG_DOT_CYC      (((`TVG_DOT_NS / `TVG_CLK_NS) < 1) ? 1 : \
                          (`TVG_DOT_NS / `TVG_CLK_NS))

`endif

// >>> core/tvg_pkg.sv
// Purpose: types of the text video timing generator
// Assumes: nothing
// Notes:   host access sequencer states
package tvg_pkg;
  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_WAIT = 3'b010,
    HS_DONE = 3'b100
  } tvg_host_e;
  typedef logic [10:0] tvg_addr_t;
endpackage

// >>> core/tvg_line_ctr.sv
// Purpose: glyph line counter, nine lines per text row
// Assumes: step is a one-cycle pulse at blanking start
// Notes:   row_tick pulses on reload after line eight
`timescale 1ns/100ps
`include "tvg_map.svh"
module tvg_line_ctr
  import tvg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       step,
  output logic [3:0]      line,
  output logic            first_line,
  output logic            row_tick
);
  wire last_line = (line == `TVG_LINE_LAST);

  // Count lines, flag line zero, tick on reload
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line       <= 4'h0;
      first_line <= 1'b1;
      row_tick   <= 1'b0;
    end else begin
      row_tick <= step & last_line; // RULE6
      if (step) begin
        line       <= last_line ? 4'h0 : line + 4'h1; // RULE6
        first_line <= last_line;
      end
    end
  end

  a_line_wrap: assert property (@(posedge clk) disable iff (rst) // RULE6
    step && last_line |=> line == 4'h0 && row_tick && first_line)
    else $error("glyph line counter did not wrap after nine");
endmodule // tvg_line_ctr

// >>> core/tvg_dot_shift.sv
// Purpose: dot shift register with reverse video
// Assumes: char_tick one cycle in seven
// Notes:   blanking loads zeros so the shifter stays clear
`timescale 1ns/100ps
`include "tvg_map.svh"
module tvg_dot_shift
  import tvg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       char_tick,
  input  wire logic       blank,
  input  wire logic [7:0] glyph_bits,
  input  wire logic       reverse_video_bit,
  output logic            video_out
);
  logic [6:0] shreg;
  logic       rev;

  // Load per character, shift one dot per clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shreg     <= 7'h00;
      rev       <= 1'b0;
      video_out <= 1'b0;
    end else begin
      if (char_tick) begin
        shreg <= blank ? 7'h00 : glyph_bits[6:0]; // RULE20 RULE22
        rev   <= reverse_video_bit & ~blank; // RULE22
      end else begin
        shreg <= {shreg[5:0], 1'b0}; // RULE20
      end
      video_out <= shreg[6] ^ rev; // RULE21
    end
  end

  a_blank_clear: assert property (@(posedge clk) disable iff (rst) // RULE22
    char_tick && blank |=> shreg == 7'h00 ##1 video_out == 1'b0)
    else $error("dot shifter not cleared in blanking");
  a_video_xor: assert property (@(posedge clk) disable iff (rst) // RULE21
    video_out == ($past(shreg[6]) ^ $past(rev)))
    else $error("video output is not the registered xor");
endmodule // tvg_dot_shift

// >>> testbench/tvg_monitor.sv
// Purpose: monitor-side model, glyph ROM and timing meter
// Assumes: glyph ROM answers combinationally, like a plain ROM
// Notes:   meas[0]-meas[4] and meas[6] hold widths in clk cycles; meas[5] counts syncs, meas[7] flags
`timescale 1ns/100ps
module tvg_monitor (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        char_tick,
  input  wire logic        line_blank_term,
  input  wire logic        hsync,
  input  wire logic        vsync,
  input  wire logic        pclk,
  input  wire logic        video_out,
  input  wire logic [10:0] glyph_rom_addr,
  output logic      [7:0]  glyph_rom_data,
  output logic      [31:0] meas [8]
);
  logic [31:0] cyc, t_tick, t_blank, t_live, t_sync, t_vs;
  logic        blank_q, sync_q, vs_q, pclk_q, vs_seen;

  // Pattern changes with both code and line
  assign glyph_rom_data = {glyph_rom_addr[3:0], glyph_rom_addr[10:7]} ^ 8'hA5;

  // Timestamps of edges, widths kept in meas
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cyc <= 32'h0; t_tick <= 32'h0; t_blank <= 32'h0;
      t_live <= 32'h0; t_sync <= 32'h0; t_vs <= 32'h0;
      for (int i = 0; i < 8; i++) meas[i] <= 32'h0;
      blank_q <= 1'b1; sync_q <= 1'b0; vs_q <= 1'b0;
      pclk_q <= 1'b1; vs_seen <= 1'b0;
    end else begin
      cyc <= cyc + 32'h1;
      blank_q <= line_blank_term; sync_q <= hsync;
      vs_q <= vsync; pclk_q <= pclk;
      if (char_tick) begin
        meas[0] <= cyc - t_tick; t_tick <= cyc;
      end
      if (line_blank_term && !blank_q) begin
        meas[1] <= cyc - t_blank; meas[2] <= cyc - t_live; t_blank <= cyc;
      end
      if (!line_blank_term && blank_q) t_live <= cyc;
      if (hsync && !sync_q) begin
        meas[4] <= cyc - t_blank; t_sync <= cyc;
        if (!vs_seen) meas[5] <= meas[5] + 32'h1;
      end
      if (!hsync && sync_q) meas[3] <= cyc - t_sync;
      if (vsync && !vs_q) begin
        vs_seen <= 1'b1; t_vs <= cyc;
      end
      if (!vsync && vs_q) meas[6] <= cyc - t_vs;
      if (pclk === pclk_q) meas[7][0] <= 1'b1;
      if (video_out !== 1'b0) meas[7][1] <= 1'b1;
    end
  end
endmodule // tvg_monitor

// >>> testbench/testbench.sv
// Purpose: self-checking bench for the text video timing block
// Assumes: host holds each request until host_ready
// Notes:   whole run stays in vertical blanking, rows 245..253
`timescale 1ns/100ps
module testbench;
  import tvg_pkg::*;
  logic        clk, rst, frame_rate_50, host_mem_rd, host_mem_wr;
  logic        host_base_wr, pclk, char_tick, line_blank_term;
  logic        frame_blank_term, host_window_select, hsync, vsync;
  logic        video_out, host_ready;
  logic [10:0] host_addr, vram_addr, glyph_rom_addr;
  logic [7:0]  host_wdata, glyph_rom_data, host_rdata, rd;
  logic [31:0] meas [8];
  int          n_errors = 0;
  int          check_count = 0;
  int          n;
  logic [10:0] addr_tab [6] = '{11'h000, 11'h007, 11'h008,
                                11'h6BF, 11'h6C0, 11'h7FF};

  tvg_top dut_u (.clk(clk), .rst(rst), .frame_rate_50(frame_rate_50),
    .host_addr(host_addr), .host_wdata(host_wdata),
    .host_mem_rd(host_mem_rd), .host_mem_wr(host_mem_wr),
    .host_base_wr(host_base_wr), .glyph_rom_data(glyph_rom_data),
    .pclk(pclk), .char_tick(char_tick), .line_blank_term(line_blank_term),
    .frame_blank_term(frame_blank_term),
    .host_window_select(host_window_select), .hsync(hsync),
    .vsync(vsync), .video_out(video_out), .host_ready(host_ready),
    .host_rdata(host_rdata), .vram_addr(vram_addr),
    .glyph_rom_addr(glyph_rom_addr));

  tvg_monitor mon_u (.clk(clk), .rst(rst), .char_tick(char_tick),
    .line_blank_term(line_blank_term), .hsync(hsync), .vsync(vsync),
    .pclk(pclk), .video_out(video_out), .glyph_rom_addr(glyph_rom_addr),
    .glyph_rom_data(glyph_rom_data), .meas(meas));

  // Dot clock, 50 ns period
  initial clk = 1'b0;
  always #25 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    if (n_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Bounded wait for vsync (sel 0) or line blanking (sel 1)
  task automatic wait_sig(input int sel, input logic lvl, input int lim);
    int k;
    k = 0;
    while (((sel == 0) ? vsync : line_blank_term) !== lvl && k < lim) begin
      @(posedge clk);
      k++;
    end
    if (k >= lim) begin
      n_errors++;
      finish_test();
    end
  endtask

  // One host memory cycle, request held until host_ready
  task automatic access(input logic wr, input logic [10:0] a,
                        input logic [7:0] d, output logic [7:0] q,
                        output int cnt);
    logic sync_prev, sync_now;
    sync_now = 1'b0;
    @(posedge clk);
    host_addr <= a;
    host_wdata <= d;
    host_mem_wr <= wr;
    host_mem_rd <= ~wr;
    cnt = 0;
    do begin
      sync_prev = sync_now;
      @(posedge clk);
      sync_now = hsync;
      cnt++;
    end while (host_ready !== 1'b1 && cnt < 3000);
    if (cnt >= 3000) begin
      n_errors++;
      finish_test();
    end
    q = host_rdata;
    check(host_window_select, 1'b1);
    check(sync_prev, 1'b1);
    check(vram_addr, a);
    host_mem_wr <= 1'b0;
    host_mem_rd <= 1'b0;
    @(posedge clk);
  endtask

  // Horizontal figures, vsync width, pclk and blank video, common to both variants
  task automatic check_line;
    @(posedge clk); // Let the monitor's last width land
    check(meas[0], 32'd7);
    check(meas[1], 32'd714);
    check(meas[2], 32'd504);
    check(meas[3], 32'd56);
    check(meas[4], 32'd70);
    check(meas[6], 32'd6426);
    check(meas[7][0], 1'b0);
    check(meas[7][1], 1'b0);
    check(frame_blank_term, 1'b1);
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    frame_rate_50 = 1'b1;
    host_addr = 11'h000;
    host_wdata = 8'h00;
    host_mem_rd = 1'b0;
    host_mem_wr = 1'b0;
    host_base_wr = 1'b0;
    repeat (8) @(posedge clk);
    check(line_blank_term, 1'b1);
    check(frame_blank_term, 1'b1);
    check(hsync, 1'b0);
    rst <= 1'b0;
    @(posedge clk);
    host_wdata <= 8'h12;
    host_base_wr <= 1'b1;
    @(posedge clk);
    host_base_wr <= 1'b0;
    // Edges of the 2048 byte memory, written then read back
    for (int i = 0; i < 6; i++)
      access(1'b1, addr_tab[i], addr_tab[i][7:0] ^ 8'h5A, rd, n);
    for (int i = 0; i < 6; i++) begin
      access(1'b0, addr_tab[i], 8'h00, rd, n);
      check(rd, addr_tab[i][7:0] ^ 8'h5A);
    end
    // Request raised in live time waits for the next sync
    wait_sig(1, 1'b0, 2000);
    @(posedge clk);
    check(vram_addr, {8'h12, 3'b000});
    access(1'b1, 11'h100, 8'h3C, rd, n);
    check((n > 560) && (n < 600), 1'b1);
    // 50 Hz frame start: sync at row 250, off at 251
    wait_sig(0, 1'b1, 40000);
    check(meas[5], 32'd45);
    wait_sig(0, 1'b0, 8000);
    check_line();
    // 60 Hz: sync at line 4 of row 252, off at line 4 of 253
    rst <= 1'b1;
    frame_rate_50 <= 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    wait_sig(0, 1'b1, 55000);
    check(meas[5], 32'd67);
    wait_sig(0, 1'b0, 8000);
    check_line();
    finish_test();
  end
endmodule // testbench
